// ==== smcr_master_regs.sv ====
`timescale 1ns/1ps
// Operation
// - Register zero write pulses meter load
// - Low four bits return revision code
// - Bits six to four return family
// - Reset bit holds logic until cleared
// - Hardware reset clears it; standby meanwhile
// - Receive rate field, reset eleven
// - Transmit rate field, same encoding
// - Fixed pointer bit pins pointer 522
// - C1 format: programmed value or numbering
// - Section trace needs enable and format
// - Serial transport overhead beats section trace
// - Path trace enable selects J1 source
// - Serial path overhead beats path trace
// - Status bits mirror block interrupt requests
// - Trace bit ORs both trace buffers
// - Bit seven ORs miscellaneous block requests
// - Clearing happens in originating blocks
// - Phase flag set on error, read clears
// - Phase enable gates converter interrupt
module smcr_master_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire smcr_pkg::smcr_irq_in_s irq_in,
  input wire logic phase_align_error,
  input wire logic serial_transport_overhead_enable,
  input wire logic serial_path_overhead_enable,
  input wire logic [9:0] tx_path_pointer,
  output smcr_pkg::smcr_ctrl_s ctrl,
  output logic load_meters,
  output logic soft_reset_n,
  output logic standby,
  output logic irq
);
  import smcr_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  smcr_state_s s_r;
  smcr_state_s s_nxt;
  logic take;
  logic [7:0] rd_byte;
  logic pae_seen;
  logic conv_irq;
  logic phase_read;

  assign take = hsel && hready && htrans[1];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.load_meters = 1'b0;
    rd_byte = 8'h00;
    phase_read = 1'b0;
    // Requests come from the flopped flag so the status path is one register.
    pae_seen = phase_align_error;
    conv_irq = s_r.pae_flag && s_r.pae_irq_en;
    case (s_r.state)
      SMCR_ST_IDLE: begin
      end
      SMCR_ST_DATA: begin
        if (s_r.wr) begin
          case (s_r.idx)
            SMCR_IDX_RESET_ID: begin
              s_nxt.soft_reset = hwdata[SMCR_SOFT_RESET_BIT];
              s_nxt.load_meters = 1'b1;
            end
            SMCR_IDX_CONFIG: begin
              s_nxt.config_r = hwdata[7:0];
            end
            SMCR_IDX_PHASE_IRQ: begin
              s_nxt.pae_irq_en = hwdata[SMCR_PAE_IRQ_EN_BIT];
            end
            default: begin
            end
          endcase
        end else if (s_r.idx == SMCR_IDX_PHASE_IRQ) begin
          phase_read = 1'b1;
        end
      end
      default: begin
        s_nxt.state = SMCR_ST_IDLE;
      end
    endcase
    // The flag is read from the value captured here, so a read clears it
    // only after the data phase has already shown it. An error in the same
    // cycle as the clearing read wins.
    if (phase_read) begin
      s_nxt.pae_flag = 1'b0;
    end
    if (pae_seen) begin
      s_nxt.pae_flag = 1'b1;
    end
    // While soft reset is held, the configuration, the phase enable and flag
    // and the status byte return to reset values.
    if (s_r.soft_reset) begin
      s_nxt.config_r = SMCR_CONFIG_RESET;
      s_nxt.pae_irq_en = 1'b0;
      s_nxt.pae_flag = 1'b0;
    end
    // Mirror only, no latching here; clearing is done at the source.
    s_nxt.irq_status = {
      irq_in.parallel_io_irq | irq_in.z1_change_irq |
        irq_in.bit_error_rate_monitor_irq | conv_irq |
        irq_in.protection_switch_irq,
      irq_in.section_trace_irq | irq_in.path_trace_irq,
      1'b0,
      irq_in.tx_cell_irq,
      irq_in.rx_cell_irq,
      irq_in.rx_path_irq,
      irq_in.rx_line_irq,
      irq_in.rx_section_irq
    };
    if (s_r.soft_reset) begin
      s_nxt.irq_status = 8'h00;
    end
    s_nxt.irq = |s_nxt.irq_status;
    // Read data for the next data phase is captured at the address phase.
    if (take) begin
      s_nxt.state = SMCR_ST_DATA;
      s_nxt.wr = hwrite;
      s_nxt.idx = (haddr[31:10] == 22'h00_0000) ? haddr[9:2] : 8'hff;
      if (!hwrite) begin
        case (s_nxt.idx)
          SMCR_IDX_RESET_ID: begin
            rd_byte = {s_r.soft_reset, SMCR_FAMILY_CODE,
              SMCR_REVISION_CODE};
          end
          SMCR_IDX_CONFIG: begin
            rd_byte = s_r.config_r;
          end
          SMCR_IDX_IRQ_STATUS: begin
            rd_byte = s_r.irq_status;
          end
          SMCR_IDX_PHASE_IRQ: begin
            rd_byte = {6'h00, s_r.pae_irq_en, s_r.pae_flag | pae_seen};
          end
          default: begin
            rd_byte = 8'h00;
          end
        endcase
      end
      s_nxt.rdata = {24'h00_0000, rd_byte};
    end else if (s_r.state == SMCR_ST_DATA) begin
      s_nxt.state = SMCR_ST_IDLE;
    end
    s_nxt.ctrl.receive_rate_select = smcr_rate_e'(s_nxt.config_r[1:0]);
    s_nxt.ctrl.transmit_rate_select = smcr_rate_e'(s_nxt.config_r[3:2]);
    s_nxt.ctrl.fixed_pointer_enable = s_nxt.config_r[4];
    s_nxt.ctrl.tx_pointer = s_nxt.config_r[4] ? SMCR_FIXED_POINTER :
      tx_path_pointer;
    s_nxt.ctrl.c1_format_select = s_nxt.config_r[5];
    s_nxt.ctrl.c1_numbered = !s_nxt.config_r[5];
    if (serial_transport_overhead_enable) begin
      s_nxt.ctrl.first_c1_src = SMCR_SRC_SERIAL_IN;
    end else if (s_nxt.config_r[6] && s_nxt.config_r[5]) begin
      s_nxt.ctrl.first_c1_src = SMCR_SRC_TRACE_BUFFER;
    end else begin
      s_nxt.ctrl.first_c1_src = SMCR_SRC_OVERHEAD_PROC;
    end
    if (serial_path_overhead_enable) begin
      s_nxt.ctrl.j1_src = SMCR_SRC_SERIAL_IN;
    end else if (s_nxt.config_r[7]) begin
      s_nxt.ctrl.j1_src = SMCR_SRC_TRACE_BUFFER;
    end else begin
      s_nxt.ctrl.j1_src = SMCR_SRC_OVERHEAD_PROC;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r.state <= SMCR_ST_IDLE;
      s_r.idx <= 8'h00;
      s_r.wr <= 1'b0;
      s_r.config_r <= SMCR_CONFIG_RESET;
      s_r.soft_reset <= 1'b0;
      s_r.pae_irq_en <= 1'b0;
      s_r.pae_flag <= 1'b0;
      s_r.load_meters <= 1'b0;
      s_r.irq_status <= 8'h00;
      s_r.irq <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
      s_r.ctrl.receive_rate_select <= SMCR_RATE_STS12C_BYTE;
      s_r.ctrl.transmit_rate_select <= SMCR_RATE_STS12C_BYTE;
      s_r.ctrl.fixed_pointer_enable <= 1'b1;
      s_r.ctrl.tx_pointer <= SMCR_FIXED_POINTER;
      s_r.ctrl.c1_format_select <= 1'b0;
      s_r.ctrl.c1_numbered <= 1'b1;
      s_r.ctrl.first_c1_src <= SMCR_SRC_OVERHEAD_PROC;
      s_r.ctrl.j1_src <= SMCR_SRC_OVERHEAD_PROC;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign ctrl = s_r.ctrl;
  assign load_meters = s_r.load_meters;
  assign soft_reset_n = !s_r.soft_reset;
  assign standby = s_r.soft_reset;
  assign irq = s_r.irq;

endmodule

// ==== smcr_pkg.sv ====
package smcr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [7:0] SMCR_IDX_RESET_ID = 8'h00;
  localparam logic [7:0] SMCR_IDX_CONFIG = 8'h01;
  localparam logic [7:0] SMCR_IDX_IRQ_STATUS = 8'h02;
  localparam logic [7:0] SMCR_IDX_PHASE_IRQ = 8'h03;
  localparam logic [7:0] SMCR_IDX_LAST = 8'h03;

  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int SMCR_SOFT_RESET_BIT = 7;
  localparam int SMCR_FAMILY_LSB = 4;
  localparam int SMCR_PAE_IRQ_EN_BIT = 1;
  localparam int SMCR_PAE_FLAG_BIT = 0;
  // Arbitrary neutral identity values.
  localparam logic [2:0] SMCR_FAMILY_CODE = 3'h5;
  localparam logic [3:0] SMCR_REVISION_CODE = 4'h7;
  localparam logic [7:0] SMCR_CONFIG_RESET = 8'h1f;
  localparam logic [9:0] SMCR_FIXED_POINTER = 10'd522;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    SMCR_RATE_STS1_BYTE = 2'b00,
    SMCR_RATE_STS3C_BYTE = 2'b01,
    SMCR_RATE_STS1_BIT = 2'b10,
    SMCR_RATE_STS12C_BYTE = 2'b11
  } smcr_rate_e;

  typedef enum logic [1:0] {
    SMCR_ST_IDLE = 2'b00,
    SMCR_ST_DATA = 2'b01
  } smcr_state_e;

  typedef enum logic [1:0] {
    SMCR_SRC_OVERHEAD_PROC = 2'b00,
    SMCR_SRC_SERIAL_IN = 2'b01,
    SMCR_SRC_TRACE_BUFFER = 2'b11
  } smcr_src_e;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic rx_section_irq;
    logic rx_line_irq;
    logic rx_path_irq;
    logic rx_cell_irq;
    logic tx_cell_irq;
    logic section_trace_irq;
    logic path_trace_irq;
    logic parallel_io_irq;
    logic z1_change_irq;
    logic bit_error_rate_monitor_irq;
    logic protection_switch_irq;
  } smcr_irq_in_s;

  typedef struct packed {
    smcr_rate_e receive_rate_select;
    smcr_rate_e transmit_rate_select;
    logic fixed_pointer_enable;
    logic [9:0] tx_pointer;
    logic c1_format_select;
    logic c1_numbered;
    smcr_src_e first_c1_src;
    smcr_src_e j1_src;
  } smcr_ctrl_s;

  typedef struct packed {
    smcr_state_e state;
    logic [7:0] idx;
    logic wr;
    logic [7:0] config_r;
    logic soft_reset;
    logic pae_irq_en;
    logic pae_flag;
    logic load_meters;
    logic [7:0] irq_status;
    logic irq;
    logic [31:0] rdata;
    smcr_ctrl_s ctrl;
  } smcr_state_s;

endpackage

// ==== smcr_master_regs_asserts.sv ====
`timescale 1ns/1ps
module smcr_master_regs_asserts
  import smcr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire smcr_irq_in_s irq_in,
  input wire smcr_ctrl_s ctrl,
  input wire logic load_meters,
  input wire logic soft_reset_n,
  input wire logic standby,
  input wire logic irq
);
  logic take;
  logic wr0;
  assign take = hsel && hready && htrans[1];
  assign wr0 = take && hwrite && haddr == 32'h0;
  default clocking
    @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_meter_load: assert property (wr0 |=> ##1 load_meters)
    else $error("meter load pulse missing");
  chk_meter_cause: assert property (load_meters |-> $past(wr0, 2))
    else $error("meter load without write");
  chk_id_read: assert property (take && !hwrite && haddr == 32'h0
    |=> hrdata[6:0] == {SMCR_FAMILY_CODE, SMCR_REVISION_CODE})
    else $error("identity field wrong");
  chk_soft_reset: assert property (wr0 |=> ##1
    soft_reset_n == !$past(hwdata[7])) else $error("reset bit wrong");
  chk_standby_lvl: assert property (standby != soft_reset_n)
    else $error("standby not tied to soft reset");
  chk_reset_rates: assert property (!soft_reset_n && !$past(soft_reset_n)
    |-> ctrl.receive_rate_select == SMCR_RATE_STS12C_BYTE &&
    ctrl.transmit_rate_select == SMCR_RATE_STS12C_BYTE)
    else $error("rates not at reset value");
  chk_fixed_ptr: assert property (ctrl.fixed_pointer_enable
    |-> ctrl.tx_pointer == SMCR_FIXED_POINTER) else $error("pointer not fixed");
  chk_c1_number: assert property (ctrl.c1_numbered != ctrl.c1_format_select)
    else $error("c1 numbering wrong");
  chk_c1_trace: assert property (ctrl.first_c1_src == SMCR_SRC_TRACE_BUFFER
    |-> ctrl.c1_format_select) else $error("section trace without format");
  chk_status_rsvd: assert property (take && !hwrite && haddr == 32'h8
    |=> hrdata[5] == 1'b0) else $error("reserved status bit set");
  chk_irq_level: assert property ((irq_in != '0 && soft_reset_n)[*3]
    |=> irq) else $error("irq not raised");
endmodule

bind smcr_master_regs smcr_master_regs_asserts u_chk (.*);

// ==== smcr_master_regs_tb.sv ====
`timescale 1ns/1ps
module smcr_master_regs_tb;
  import smcr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] tx_path_pointer;
  logic phase_align_error, serial_transport_overhead_enable;
  logic serial_path_overhead_enable, load_meters, soft_reset_n, standby, irq;
  smcr_irq_in_s irq_in;
  smcr_ctrl_s ctrl;
  logic [7:0] seed, v, id;
  int n_errors, compares, cyc;
  assign hready = hreadyout;
  assign id = {1'b0, SMCR_FAMILY_CODE, SMCR_REVISION_CODE};
  smcr_master_regs dut (.*);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] stat(input smcr_irq_in_s s);
    return {s.parallel_io_irq | s.z1_change_irq |
      s.bit_error_rate_monitor_irq | s.protection_switch_irq,
      s.section_trace_irq | s.path_trace_irq, 1'b0, s.tx_cell_irq,
      s.rx_cell_irq, s.rx_path_irq, s.rx_line_irq, s.rx_section_irq};
  endfunction
  // Serial insertion wins over the trace buffer, which wins over the proc.
  function automatic logic [1:0] src(input logic ser, input logic trc);
    return ser ? 2'b01 : (trc ? 2'b11 : 2'b00);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk(r, {24'h0, e});
  endtask
  task automatic pulse_err;
    phase_align_error <= 1'b1;
    @(posedge hclk);
    phase_align_error <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {hresetn, hsel, hwrite, phase_align_error} = 4'h0;
    {haddr, hwdata, htrans, tx_path_pointer} = '0;
    {serial_transport_overhead_enable, serial_path_overhead_enable} = 2'b00;
    hsize = 3'b010;
    irq_in = '0;
    seed = 8'h23;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h0, id);
    rd(32'h4, 8'h1f);
    rd(32'hc, 8'h00);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      v = {seed[7:4], i[1:0], i[1:0]};
      serial_transport_overhead_enable <= seed[0];
      serial_path_overhead_enable <= seed[1];
      tx_path_pointer <= {seed, 2'b01};
      xfer(1'b1, 32'h0, 32'h80);
      xfer(1'b1, 32'h0, 32'h0);
      xfer(1'b1, 32'h4, {24'h0, v});
      rd(32'h4, v);
      chk(ctrl.receive_rate_select, v[1:0]);
      chk(ctrl.transmit_rate_select, v[3:2]);
      chk(ctrl.tx_pointer, v[4] ? 10'd522 : tx_path_pointer);
      chk(ctrl.c1_numbered, !v[5]);
      chk(ctrl.fixed_pointer_enable, v[4]);
      chk(ctrl.c1_format_select, v[5]);
      chk(ctrl.first_c1_src, src(seed[0], v[6] & v[5]));
      chk(ctrl.j1_src, src(seed[1], v[7]));
    end
    xfer(1'b1, 32'h10, 32'hff);
    rd(32'h10, 8'h00);
    chk(hresp, 1'b0);
    xfer(1'b1, 32'h0, 32'h0);
    #1 chk(load_meters, 1'b1);
    @(posedge hclk);
    #1 chk(load_meters, 1'b0);
    xfer(1'b1, 32'h0, 32'h80);
    #1 chk({soft_reset_n, standby}, 2'b01);
    rd(32'h0, id | 8'h80);
    rd(32'h4, 8'h1f);
    xfer(1'b1, 32'h0, 32'h0);
    #1 chk(soft_reset_n, 1'b1);
    xfer(1'b1, 32'h0, 32'h80);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h0, id);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      irq_in <= (i == 11) ? '0 : {seed[2:0], seed};
      repeat (3) @(posedge hclk);
      chk(irq, |stat(irq_in));
      rd(32'h8, stat(irq_in));
    end
    xfer(1'b1, 32'hc, 32'h2);
    pulse_err();
    chk(irq, 1'b1);
    rd(32'hc, 8'h03);
    rd(32'hc, 8'h02);
    repeat (3) @(posedge hclk);
    chk(irq, 1'b0);
    xfer(1'b1, 32'hc, 32'h0);
    pulse_err();
    chk(irq, 1'b0);
    rd(32'hc, 8'h01);
    end_sim();
  end
endmodule
